// ---- logic/emd_datapath.sv ----
// Extended memory-operand instruction datapath: sequencer and held state.
// ============================================================================
`timescale 1ns/1ns
module emd_datapath #(
  parameter int DATA_AW = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input emd_pkg::emd_op_t op,
  input wire logic [DATA_AW-1:0] operand_addr,
  input wire logic [2:0] bit_sel,
  input wire logic work_load,
  input wire logic [7:0] work_load_data,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_load_low,
  input wire logic [7:0] ptr_load_high,
  input wire logic [7:0] mem_rd_data,
  input wire logic [15:0] prog_data,
  output logic busy_r,
  output logic done_r,
  output logic skip_r,
  output logic [DATA_AW-1:0] mem_addr_r,
  output logic mem_rd_en_r,
  output logic mem_wr_en_r,
  output logic [7:0] mem_wr_data_r,
  output logic prog_rd_en_r,
  output logic [15:0] prog_addr_r,
  output logic [7:0] work_register_r,
  output logic [7:0] table_ptr_low_r,
  output logic [7:0] table_ptr_high_r,
  output logic [7:0] table_high_latch_r,
  output logic [5:0] flags_r
);

  // ==========================================================================
  // Sequencer state
  typedef enum logic [2:0] {
    IDLE,
    MEM_RD,
    TBL_RD,
    EXEC,
    DUMMY
  } emd_state_t;

  emd_state_t state_r;
  emd_pkg::emd_op_t op_r;
  logic [2:0] bit_r;
  logic accept;
  logic is_tbl;
  logic is_incr;
  logic is_last;
  logic tbl_r;
  logic [7:0] ptr_low_nxt;
  logic [7:0] alu_res;
  logic [5:0] alu_flags;
  logic alu_mem;
  logic alu_work;
  logic alu_skip;
  logic exec;
  logic skip_taken;

  assign accept = (state_r == IDLE) && start;
  assign is_incr = (op == emd_pkg::table_read_incr) ||
    (op == emd_pkg::table_read_incr_last);
  assign is_last = (op == emd_pkg::table_read_last) ||
    (op == emd_pkg::table_read_incr_last);
  assign is_tbl = is_incr || is_last || (op == emd_pkg::table_read_current);
  assign ptr_low_nxt = is_incr ? table_ptr_low_r + 8'h01 : table_ptr_low_r;
  assign exec = (state_r == EXEC);
  assign skip_taken = exec && !tbl_r && alu_skip;

  emd_alu u_alu (
    .op(op_r),
    .operand(mem_rd_data),
    .work(work_register_r),
    .flags_in(flags_r),
    .bit_sel(bit_r),
    .result(alu_res),
    .flags_out(alu_flags),
    .to_mem(alu_mem),
    .to_work(alu_work),
    .skip(alu_skip)
  );

  // ==========================================================================
  // Instruction sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= IDLE;
    end else begin
      unique case (state_r)
        IDLE: begin
          if (start) begin
            state_r <= is_tbl ? TBL_RD : MEM_RD;
          end
        end
        MEM_RD: begin
          state_r <= EXEC;
        end
        TBL_RD: begin
          state_r <= EXEC;
        end
        EXEC: begin
          state_r <= skip_taken ? DUMMY : IDLE;
        end
        DUMMY: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op_r <= emd_pkg::rot_right;
      bit_r <= 3'h0;
      tbl_r <= 1'b0;
    end else if (accept) begin
      op_r <= op;
      bit_r <= bit_sel;
      tbl_r <= is_tbl;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      busy_r <= accept || state_r == MEM_RD || state_r == TBL_RD ||
        skip_taken;
      done_r <= (exec && !skip_taken) || state_r == DUMMY;
      skip_r <= skip_taken;
    end
  end

  // ==========================================================================
  // Data memory port
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_addr_r <= '0;
      mem_rd_en_r <= 1'b0;
    end else begin
      mem_rd_en_r <= accept && !is_tbl;
      if (accept) begin
        mem_addr_r <= operand_addr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_wr_en_r <= 1'b0;
      mem_wr_data_r <= emd_pkg::BYTE_ZERO;
    end else begin
      mem_wr_en_r <= exec && (tbl_r || alu_mem);
      if (exec) begin
        mem_wr_data_r <= tbl_r ? prog_data[7:0] : alu_res;
      end
    end
  end

  // ==========================================================================
  // Table pointer, program memory port and high-byte latch
  always_ff @(posedge clk) begin
    if (reset) begin
      table_ptr_low_r <= emd_pkg::PTR_RST;
      table_ptr_high_r <= emd_pkg::PTR_RST;
    end else if (accept && is_tbl) begin
      table_ptr_low_r <= ptr_low_nxt;
    end else if (state_r == IDLE && ptr_load) begin
      table_ptr_low_r <= ptr_load_low;
      table_ptr_high_r <= ptr_load_high;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prog_rd_en_r <= 1'b0;
      prog_addr_r <= 16'h0000;
    end else begin
      prog_rd_en_r <= accept && is_tbl;
      if (accept && is_tbl) begin
        prog_addr_r <= is_last ? {emd_pkg::PAGE_LAST, ptr_low_nxt}
          : {table_ptr_high_r, ptr_low_nxt};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      table_high_latch_r <= emd_pkg::BYTE_ZERO;
    end else if (exec && tbl_r) begin
      table_high_latch_r <= prog_data[15:8];
    end
  end

  // ==========================================================================
  // Working register and flags
  always_ff @(posedge clk) begin
    if (reset) begin
      work_register_r <= emd_pkg::WORK_RST;
    end else if (exec && !tbl_r && alu_work) begin
      work_register_r <= alu_res;
    end else if (state_r == IDLE && work_load) begin
      work_register_r <= work_load_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= emd_pkg::FLAGS_RST;
    end else if (exec && !tbl_r) begin
      flags_r <= alu_flags;
    end
  end

  // ==========================================================================
  // Checks
  logic [7:0] prev_opnd_r;
  logic [7:0] prev_work_r;
  logic [5:0] prev_flags_r;
  logic [15:0] prev_prog_r;
  logic [2:0] prev_bit_r;

  always_ff @(posedge clk) begin
    prev_opnd_r <= mem_rd_data;
    prev_work_r <= work_register_r;
    prev_flags_r <= flags_r;
    prev_prog_r <= prog_data;
    prev_bit_r <= bit_r;
  end

  sequence exec_s(emd_pkg::emd_op_t o);
    state_r == EXEC && op_r == o;
  endsequence

  sequence skip_tail_s;
    skip_r && !done_r ##1 done_r && !skip_r;
  endsequence

  rot_mem_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::rot_right) |=> mem_wr_en_r &&
    mem_wr_data_r == {prev_opnd_r[0], prev_opnd_r[7:1]} &&
    flags_r == prev_flags_r)
    else $error("plain rotate result or flags wrong");

  rot_work_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::rot_right_to_work) |=> !mem_wr_en_r &&
    work_register_r == {prev_opnd_r[0], prev_opnd_r[7:1]})
    else $error("rotate to work register wrong");

  rot_carry_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::rot_right_carry) |=> mem_wr_en_r &&
    mem_wr_data_r == {prev_flags_r[emd_pkg::FLAG_C], prev_opnd_r[7:1]} &&
    flags_r[emd_pkg::FLAG_C] == prev_opnd_r[0] &&
    flags_r[5:1] == prev_flags_r[5:1])
    else $error("rotate through carry wrong");

  sbc_mem_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::sub_borrow_to_mem) |=> mem_wr_en_r &&
    mem_wr_data_r == 8'(prev_work_r - prev_opnd_r -
    {7'h00, ~prev_flags_r[emd_pkg::FLAG_C]}))
    else $error("subtract with borrow result wrong");

  sub_carry_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::subtract_plain) |=>
    flags_r[emd_pkg::FLAG_C] == (prev_work_r >= prev_opnd_r))
    else $error("subtract carry not inverted borrow");

  sub_work_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::subtract_plain) |=> !mem_wr_en_r &&
    work_register_r == 8'(prev_work_r - prev_opnd_r) &&
    flags_r[emd_pkg::FLAG_Z] == (prev_work_r == prev_opnd_r))
    else $error("plain subtract wrong");

  dec_skip_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::dec_skip_zero) |=> mem_wr_en_r &&
    mem_wr_data_r == 8'(prev_opnd_r - 8'h01) &&
    skip_r == (prev_opnd_r == 8'h01) && flags_r == prev_flags_r)
    else $error("decrement skip wrong");

  inc_skip_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::inc_skip_zero) |=> mem_wr_en_r &&
    mem_wr_data_r == 8'(prev_opnd_r + 8'h01) &&
    skip_r == (prev_opnd_r == 8'hff))
    else $error("increment skip wrong");

  inc_work_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::inc_skip_zero_to_work) |=> !mem_wr_en_r &&
    work_register_r == 8'(prev_opnd_r + 8'h01))
    else $error("increment to work register wrong");

  skip_dummy_a: assert property (@(posedge clk) disable iff (reset)
    skip_r |-> skip_tail_s)
    else $error("taken skip lacks one dummy cycle");

  set_byte_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::set_all_bits) |=> mem_wr_en_r &&
    mem_wr_data_r == 8'hff && flags_r == prev_flags_r)
    else $error("byte set wrong");

  nonzero_skip_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::skip_nonzero) |=> !mem_wr_en_r &&
    skip_r == (prev_opnd_r != 8'h00))
    else $error("nonzero skip wrong");

  swap_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::nibble_exchange_to_work) |=> !mem_wr_en_r &&
    work_register_r == {prev_opnd_r[3:0], prev_opnd_r[7:4]})
    else $error("nibble exchange wrong");

  copy_zero_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::copy_skip_if_zero) |=> work_register_r == prev_opnd_r &&
    skip_r == (prev_opnd_r == 8'h00))
    else $error("copying zero test wrong");

  bit_zero_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::skip_zero_bit) |=>
    skip_r == !prev_opnd_r[prev_bit_r])
    else $error("bit test skip wrong");

  tbl_write_a: assert property (@(posedge clk) disable iff (reset)
    state_r == EXEC && tbl_r |=> mem_wr_en_r &&
    mem_wr_data_r == prev_prog_r[7:0] &&
    table_high_latch_r == prev_prog_r[15:8] && flags_r == prev_flags_r)
    else $error("table read transfer wrong");

  tbl_last_a: assert property (@(posedge clk) disable iff (reset)
    accept && op == emd_pkg::table_read_last |=> prog_rd_en_r &&
    prog_addr_r == {8'hff, table_ptr_low_r} ##1 state_r == EXEC)
    else $error("last page address wrong");

  tbl_incr_a: assert property (@(posedge clk) disable iff (reset)
    accept && op == emd_pkg::table_read_incr |=> prog_rd_en_r &&
    table_ptr_low_r == 8'($past(table_ptr_low_r) + 8'h01) &&
    prog_addr_r == {table_ptr_high_r, table_ptr_low_r})
    else $error("incrementing table read wrong");

  xor_a: assert property (@(posedge clk) disable iff (reset)
    exec_s(emd_pkg::xor_to_mem) |=> mem_wr_en_r &&
    mem_wr_data_r == (prev_work_r ^ prev_opnd_r) &&
    flags_r[5:2] == prev_flags_r[5:2] &&
    flags_r[emd_pkg::FLAG_C] == prev_flags_r[emd_pkg::FLAG_C])
    else $error("xor result or flags wrong");

  flag_hold_a: assert property (@(posedge clk) disable iff (reset)
    state_r == DUMMY |=> $stable(flags_r))
    else $error("flags changed in dummy cycle");

endmodule

// ---- logic/emd_pkg.sv ----
// Shared constants and types for the extended memory-operand datapath.
package emd_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int PROG_W = 16;
  localparam int PAGE_W = 8;
  localparam int FLAGS_W = 6;

  // ==========================================================================
  // Flag positions in the status bus
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_SIGN = 4;
  localparam int FLAG_CHAIN = 5;

  // ==========================================================================
  // Constant values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] PAGE_LAST = 8'hff;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;

  // ==========================================================================
  // Operations
  typedef enum logic [4:0] {
    rot_right,
    rot_right_to_work,
    rot_right_carry,
    rot_right_carry_to_work,
    sub_borrow,
    sub_borrow_to_mem,
    subtract_plain,
    subtract_to_mem,
    dec_skip_zero,
    dec_skip_zero_to_work,
    inc_skip_zero,
    inc_skip_zero_to_work,
    set_all_bits,
    set_one_bit,
    skip_nonzero,
    skip_nonzero_bit,
    nibble_exchange,
    nibble_exchange_to_work,
    skip_if_zero,
    copy_skip_if_zero,
    skip_zero_bit,
    table_read_current,
    table_read_last,
    table_read_incr,
    table_read_incr_last,
    xor_to_work,
    xor_to_mem
  } emd_op_t;

endpackage

// ---- logic/emd_alu.sv ----
// Combinational result, flag and skip logic for one memory-operand operation.
`timescale 1ns/1ns
module emd_alu (
  input emd_pkg::emd_op_t op,
  input wire logic [7:0] operand,
  input wire logic [7:0] work,
  input wire logic [5:0] flags_in,
  input wire logic [2:0] bit_sel,
  output logic [7:0] result,
  output logic [5:0] flags_out,
  output logic to_mem,
  output logic to_work,
  output logic skip
);

  logic borrow_in;
  logic [8:0] diff;
  logic [4:0] nib;
  logic ov;
  logic z;

  // Carry reads as an inverted borrow on the way in and on the way out.
  assign borrow_in = (op == emd_pkg::sub_borrow ||
    op == emd_pkg::sub_borrow_to_mem) ? ~flags_in[emd_pkg::FLAG_C] : 1'b0;
  assign diff = {1'b0, work} - {1'b0, operand} - {8'h00, borrow_in};
  assign nib = {1'b0, work[3:0]} - {1'b0, operand[3:0]} - {4'h0, borrow_in};
  assign ov = (work[7] ^ operand[7]) & (work[7] ^ diff[7]);
  assign z = (diff[7:0] == emd_pkg::BYTE_ZERO);

  always_comb begin
    result = operand;
    flags_out = flags_in;
    to_mem = 1'b0;
    to_work = 1'b0;
    skip = 1'b0;
    unique case (op)
      emd_pkg::rot_right, emd_pkg::rot_right_to_work: begin
        result = {operand[0], operand[7:1]};
        to_mem = (op == emd_pkg::rot_right);
        to_work = !to_mem;
      end
      emd_pkg::rot_right_carry, emd_pkg::rot_right_carry_to_work: begin
        result = {flags_in[emd_pkg::FLAG_C], operand[7:1]};
        flags_out[emd_pkg::FLAG_C] = operand[0];
        to_mem = (op == emd_pkg::rot_right_carry);
        to_work = !to_mem;
      end
      emd_pkg::sub_borrow, emd_pkg::sub_borrow_to_mem,
      emd_pkg::subtract_plain, emd_pkg::subtract_to_mem: begin
        result = diff[7:0];
        flags_out[emd_pkg::FLAG_C] = ~diff[8];
        flags_out[emd_pkg::FLAG_HALF] = ~nib[4];
        flags_out[emd_pkg::FLAG_WRAP] = ov;
        flags_out[emd_pkg::FLAG_Z] = z;
        flags_out[emd_pkg::FLAG_SIGN] = diff[7] ^ ov;
        flags_out[emd_pkg::FLAG_CHAIN] = (op == emd_pkg::sub_borrow ||
          op == emd_pkg::sub_borrow_to_mem) ?
          (z & flags_in[emd_pkg::FLAG_CHAIN]) : z;
        to_mem = (op == emd_pkg::sub_borrow_to_mem ||
          op == emd_pkg::subtract_to_mem);
        to_work = !to_mem;
      end
      emd_pkg::dec_skip_zero, emd_pkg::dec_skip_zero_to_work: begin
        result = operand - emd_pkg::BYTE_ONE;
        skip = (result == emd_pkg::BYTE_ZERO);
        to_mem = (op == emd_pkg::dec_skip_zero);
        to_work = !to_mem;
      end
      emd_pkg::inc_skip_zero, emd_pkg::inc_skip_zero_to_work: begin
        result = operand + emd_pkg::BYTE_ONE;
        skip = (result == emd_pkg::BYTE_ZERO);
        to_mem = (op == emd_pkg::inc_skip_zero);
        to_work = !to_mem;
      end
      emd_pkg::set_all_bits: begin
        result = emd_pkg::BYTE_ONES;
        to_mem = 1'b1;
      end
      emd_pkg::set_one_bit: begin
        result[bit_sel] = 1'b1;
        to_mem = 1'b1;
      end
      emd_pkg::skip_nonzero: begin
        skip = (operand != emd_pkg::BYTE_ZERO);
      end
      emd_pkg::skip_nonzero_bit: begin
        skip = operand[bit_sel];
      end
      emd_pkg::nibble_exchange, emd_pkg::nibble_exchange_to_work: begin
        result = {operand[3:0], operand[7:4]};
        to_mem = (op == emd_pkg::nibble_exchange);
        to_work = !to_mem;
      end
      emd_pkg::skip_if_zero, emd_pkg::copy_skip_if_zero: begin
        skip = (operand == emd_pkg::BYTE_ZERO);
        to_work = (op == emd_pkg::copy_skip_if_zero);
      end
      emd_pkg::skip_zero_bit: begin
        skip = !operand[bit_sel];
      end
      emd_pkg::xor_to_work, emd_pkg::xor_to_mem: begin
        result = work ^ operand;
        flags_out[emd_pkg::FLAG_Z] = (result == emd_pkg::BYTE_ZERO);
        to_mem = (op == emd_pkg::xor_to_mem);
        to_work = !to_mem;
      end
      emd_pkg::table_read_current, emd_pkg::table_read_last,
      emd_pkg::table_read_incr, emd_pkg::table_read_incr_last: begin
        result = operand;
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

// ---- verif/extended_memory_op_datapath_bench.sv ----
// Self-checking random bench for the extended memory-operand datapath.
`timescale 1ns/1ns
module extended_memory_op_datapath_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  emd_pkg::emd_op_t op = emd_pkg::rot_right;
  logic [11:0] operand_addr = 12'h000;
  logic [2:0] bit_sel = 3'h0;
  logic work_load = 1'b0;
  logic [7:0] work_load_data = 8'h00;
  logic ptr_load = 1'b0;
  logic [7:0] ptr_load_low = 8'h00;
  logic [7:0] ptr_load_high = 8'h00;
  logic [7:0] mem_rd_data = 8'h00;
  logic [15:0] prog_data = 16'h0000;
  logic busy_r, done_r, skip_r, mem_rd_en_r, mem_wr_en_r, prog_rd_en_r;
  logic [11:0] mem_addr_r;
  logic [7:0] mem_wr_data_r, work_register_r, table_high_latch_r;
  logic [7:0] table_ptr_low_r, table_ptr_high_r;
  logic [15:0] prog_addr_r;
  logic [5:0] flags_r;
  int mismatches = 0;
  int cmp_count = 0;
  // Expected state: flags are carry, zero, half, wrap, signed, chained.
  logic [7:0] w_e, lo_e, hi_e, lat_e;
  logic [5:0] f_e;

  emd_datapath #(.DATA_AW(12)) u_emd_datapath (.clk(clk), .reset(reset),
    .start(start), .op(op), .operand_addr(operand_addr), .bit_sel(bit_sel),
    .work_load(work_load), .work_load_data(work_load_data),
    .ptr_load(ptr_load), .ptr_load_low(ptr_load_low),
    .ptr_load_high(ptr_load_high), .mem_rd_data(mem_rd_data),
    .prog_data(prog_data), .busy_r(busy_r), .done_r(done_r),
    .skip_r(skip_r), .mem_addr_r(mem_addr_r), .mem_rd_en_r(mem_rd_en_r),
    .mem_wr_en_r(mem_wr_en_r), .mem_wr_data_r(mem_wr_data_r),
    .prog_rd_en_r(prog_rd_en_r), .prog_addr_r(prog_addr_r),
    .work_register_r(work_register_r), .table_ptr_low_r(table_ptr_low_r),
    .table_ptr_high_r(table_ptr_high_r),
    .table_high_latch_r(table_high_latch_r), .flags_r(flags_r));

  always #2 clk = ~clk;

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Reference model of one operation, updating the expected state
  function automatic void predict(input emd_pkg::emd_op_t o,
      input logic [7:0] m, input logic [2:0] b, input logic [15:0] p,
      output logic [7:0] r, output logic tm, output logic tw,
      output logic sk, output logic tb, output logic [15:0] pa);
    logic [8:0] d;
    logic [4:0] h;
    logic bin;
    logic pl;
    r = m;
    tm = 1'b0;
    tw = 1'b0;
    sk = 1'b0;
    tb = 1'b0;
    pa = 16'h0000;
    case (o)
      emd_pkg::rot_right, emd_pkg::rot_right_to_work: begin
        r = {m[0], m[7:1]};
        tm = (o == emd_pkg::rot_right);
      end
      emd_pkg::rot_right_carry, emd_pkg::rot_right_carry_to_work: begin
        r = {f_e[0], m[7:1]};
        f_e[0] = m[0];
        tm = (o == emd_pkg::rot_right_carry);
      end
      emd_pkg::sub_borrow, emd_pkg::sub_borrow_to_mem,
      emd_pkg::subtract_plain, emd_pkg::subtract_to_mem: begin
        pl = (o == emd_pkg::subtract_plain || o == emd_pkg::subtract_to_mem);
        bin = pl ? 1'b0 : !f_e[0];
        d = {1'b0, w_e} - {1'b0, m} - {8'h00, bin};
        h = {1'b0, w_e[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
        r = d[7:0];
        f_e[3] = (w_e[7] != m[7]) && (r[7] != w_e[7]);
        f_e[0] = !d[8];
        f_e[2] = !h[4];
        f_e[5] = (r == 8'h00) && (pl || f_e[5]);
        f_e[1] = (r == 8'h00);
        f_e[4] = r[7] ^ f_e[3];
        tm = (o == emd_pkg::sub_borrow_to_mem ||
          o == emd_pkg::subtract_to_mem);
      end
      emd_pkg::dec_skip_zero, emd_pkg::dec_skip_zero_to_work: begin
        r = m - 8'h01;
        sk = (r == 8'h00);
        tm = (o == emd_pkg::dec_skip_zero);
      end
      emd_pkg::inc_skip_zero, emd_pkg::inc_skip_zero_to_work: begin
        r = m + 8'h01;
        sk = (r == 8'h00);
        tm = (o == emd_pkg::inc_skip_zero);
      end
      emd_pkg::set_all_bits: begin
        r = 8'hff;
        tm = 1'b1;
      end
      emd_pkg::set_one_bit: begin
        r = m | (8'h01 << b);
        tm = 1'b1;
      end
      emd_pkg::skip_nonzero: sk = (m != 8'h00);
      emd_pkg::skip_nonzero_bit: sk = m[b];
      emd_pkg::nibble_exchange, emd_pkg::nibble_exchange_to_work: begin
        r = {m[3:0], m[7:4]};
        tm = (o == emd_pkg::nibble_exchange);
      end
      emd_pkg::skip_if_zero: sk = (m == 8'h00);
      emd_pkg::copy_skip_if_zero: sk = (m == 8'h00);
      emd_pkg::skip_zero_bit: sk = !m[b];
      emd_pkg::xor_to_work, emd_pkg::xor_to_mem: begin
        r = w_e ^ m;
        f_e[1] = (r == 8'h00);
        tm = (o == emd_pkg::xor_to_mem);
      end
      default: begin
        if (o == emd_pkg::table_read_incr ||
          o == emd_pkg::table_read_incr_last) begin
          lo_e = lo_e + 8'h01;
        end
        pl = (o == emd_pkg::table_read_last ||
          o == emd_pkg::table_read_incr_last);
        pa = {pl ? 8'hff : hi_e, lo_e};
        r = p[7:0];
        lat_e = p[15:8];
        tm = 1'b1;
        tb = 1'b1;
      end
    endcase
    tw = !tm && !tb && (r !== m || o == emd_pkg::copy_skip_if_zero ||
      o inside {emd_pkg::rot_right_to_work, emd_pkg::rot_right_carry_to_work,
      emd_pkg::sub_borrow, emd_pkg::subtract_plain, emd_pkg::xor_to_work,
      emd_pkg::dec_skip_zero_to_work, emd_pkg::inc_skip_zero_to_work,
      emd_pkg::nibble_exchange_to_work});
    if (tw) begin
      w_e = r;
    end
  endfunction

  // ==========================================================================
  // Drivers
  task automatic load_regs(input logic [7:0] lo);
    @(negedge clk);
    work_load = 1'b1;
    ptr_load = 1'b1;
    work_load_data = 8'($urandom);
    ptr_load_low = lo;
    ptr_load_high = 8'($urandom);
    @(negedge clk);
    work_load = 1'b0;
    ptr_load = 1'b0;
    w_e = work_load_data;
    lo_e = lo;
    hi_e = ptr_load_high;
  endtask

  task automatic run_op(input emd_pkg::emd_op_t o, input logic [7:0] m,
      input logic [15:0] p);
    logic [7:0] r, wd;
    logic tm, tw, sk, tb, wr, sks, pr;
    logic [15:0] pa, pas;
    logic [11:0] a;
    logic [2:0] b;
    int n;
    int nb;
    int nr;
    a = 12'($urandom);
    b = 3'($urandom);
    start = 1'b1;
    op = o;
    operand_addr = a;
    bit_sel = b;
    predict(o, m, b, p, r, tm, tw, sk, tb, pa);
    wr = 1'b0;
    sks = 1'b0;
    pr = 1'b0;
    wd = 8'h00;
    pas = 16'h0000;
    n = 0;
    nb = 0;
    nr = 0;
    do begin
      @(negedge clk);
      n++;
      if (n == 1) begin
        start = 1'b0;
        mem_rd_data = m;
        prog_data = p;
      end
      if (mem_wr_en_r === 1'b1) begin
        wr = 1'b1;
        wd = mem_wr_data_r;
        chk(mem_addr_r === a, "operand address");
      end
      if (skip_r === 1'b1) sks = 1'b1;
      if (busy_r === 1'b1) nb++;
      if (mem_rd_en_r === 1'b1) nr++;
      if (prog_rd_en_r === 1'b1) begin
        pr = 1'b1;
        pas = prog_addr_r;
      end
    end while (done_r !== 1'b1 && n < 8);
    mem_rd_data = ~m;
    prog_data = ~p;
    chk(n == 3 + int'(sk), "cycle count");
    chk(nb == 2 + int'(sk), "busy span");
    chk(nr == int'(!tb), "memory read");
    chk(sks === sk, "skip");
    chk(wr === tm, "memory write");
    if (tm) chk(wd === r, "write data");
    chk(work_register_r === w_e, "work register");
    chk(flags_r === f_e, "flags");
    chk(table_high_latch_r === lat_e && table_ptr_low_r === lo_e &&
      table_ptr_high_r === hi_e, "table");
    chk(pr === tb && (!tb || pas === pa), "program address");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    void'($urandom(32'h0d88_8f4b));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    w_e = 8'h00;
    f_e = 6'h00;
    lo_e = 8'h00;
    hi_e = 8'h00;
    lat_e = 8'h00;
    chk(flags_r === 6'h00 && work_register_r === 8'h00, "reset state");
    load_regs(8'hff);
    run_op(emd_pkg::table_read_incr, 8'h00, 16'($urandom));
    run_op(emd_pkg::dec_skip_zero, 8'h01, 16'h0000);
    run_op(emd_pkg::inc_skip_zero_to_work, 8'hff, 16'h0000);
    run_op(emd_pkg::subtract_plain, w_e, 16'h0000);
    run_op(emd_pkg::sub_borrow, 8'h00, 16'h0000);
    run_op(emd_pkg::subtract_to_mem, 8'h01, 16'h0000);
    run_op(emd_pkg::sub_borrow_to_mem, 8'h00, 16'h0000);
    run_op(emd_pkg::skip_if_zero, 8'h00, 16'h0000);
    run_op(emd_pkg::skip_nonzero, 8'h00, 16'h0000);
    run_op(emd_pkg::skip_zero_bit, 8'hff, 16'h0000);
    for (int i = 0; i < 27; i++) begin
      run_op(emd_pkg::emd_op_t'(i), 8'($urandom), 16'($urandom));
    end
    repeat (400) begin
      if ($urandom % 3 == 0) load_regs(8'($urandom));
      run_op(emd_pkg::emd_op_t'($urandom % 27),
        ($urandom % 4 == 0) ? 8'h00 : 8'($urandom), 16'($urandom));
    end
    end_of_test;
  end

  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
endmodule
